// ---- core/start_sync_host.sv ----
// Contract
// - Sync lines are level coded: high means run, low means stop.
// - In Initialize the host drives sync low and clears experiment clocks.
// - Once ready the host enters Ready, raises sync, no logging or clocks.
// - In Ready a partner rising edge starts Run, clocks and logging.
// - Manual abort drops sync, stops clocks and collection, discards logs.
// - Partner stop request in Run: Halt ACK, drop sync, flush, record end time.
// - After completion the host idles with sync low and clocks stopped.
// - Partner high before host Ready enters Error, sync low, flagged.
// - Host drives sync, watches partner, accepts go only in Initialize and no-go in any state but Idle, Error and Abort.
// - Host stops clocks on the partner falling edge, then goes Idle.
module start_sync_host
    import sync_pkg::*;
(
    input wire logic sys_clk, // System clock, 100 MHz.
    input wire logic sys_rst, // Synchronous active-high reset.
    input wire host_cmd_t cmd, // One-cycle operator strobes.
    input wire logic partner_sync, // Asynchronous partner sync line.
    output logic host_sync, // Host sync line to the partner.
    output host_state_t state, // Current sequencing state.
    output host_status_t status, // Experiment status flags.
    output logic [TIME_W-1:0] exp_time, // Running experiment clock.
    output logic [TIME_W-1:0] end_time // Clock value at halt.
);

    logic sync1_q, sync2_q, prev_q;
    logic rise, fall;
    host_state_t state_q, state_d;
    logic host_sync_q, host_sync_d;
    logic [TIME_W-1:0] time_q, time_d, end_q, end_d;
    host_status_t stat_q, stat_d;

    // Two flops before anything looks at the partner line; the third holds history.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_q <= LINE_STOP;
            sync2_q <= LINE_STOP;
            prev_q <= LINE_STOP;
        end else begin
            sync1_q <= partner_sync;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Edges come from synchronised copies only, so each is seen exactly once.
    assign rise = (sync2_q == LINE_RUN) && (prev_q == LINE_STOP);
    assign fall = (sync2_q == LINE_STOP) && (prev_q == LINE_RUN);

    // Next-state logic; manual no-go takes priority so an abort works from Initialize, Ready, Run and Halt ACK.
    always_comb begin
        state_d = state_q;
        host_sync_d = host_sync_q;
        time_d = time_q;
        end_d = end_q;
        stat_d = stat_q;
        stat_d.flush_logs = 1'b0;
        if (stat_q.clocks_running) begin
            time_d = time_q + 32'h0000_0001;
        end
        if (cmd.manual_nogo_command && state_q != ST_IDLE && state_q != ST_ERROR
                && state_q != ST_ABORT) begin
            state_d = ST_ABORT;
            host_sync_d = LINE_STOP;
            stat_d.clocks_running = 1'b0;
            stat_d.logging = 1'b0;
            stat_d.discard_logs = 1'b1;
            time_d = time_q;
        end else begin
            unique case (state_q)
                ST_INIT: begin
                    host_sync_d = LINE_STOP;
                    time_d = TIME_RESET;
                    stat_d = '0;
                    if (sync2_q == LINE_RUN) begin
                        state_d = ST_ERROR;
                        stat_d.seq_error = 1'b1;
                    end else if (cmd.ready || cmd.manual_go_command) begin
                        state_d = ST_READY;
                        host_sync_d = LINE_RUN;
                    end
                end
                ST_READY: begin
                    if (rise) begin
                        state_d = ST_RUN;
                        stat_d.clocks_running = 1'b1;
                        stat_d.logging = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (fall) begin
                        state_d = ST_HALT_ACK;
                        host_sync_d = LINE_STOP;
                        stat_d.clocks_running = 1'b0;
                        stat_d.logging = 1'b0;
                        stat_d.flush_logs = 1'b1;
                        end_d = time_q;
                        time_d = time_q;
                    end
                end
                ST_ABORT: begin
                    state_d = ST_IDLE;
                end
                ST_HALT_ACK: begin
                    state_d = ST_IDLE;
                end
                ST_IDLE: begin
                    host_sync_d = LINE_STOP;
                    stat_d.clocks_running = 1'b0;
                    if (cmd.restart) begin
                        // Clear on the way in, so Initialize never shows a stale clock or flag.
                        state_d = ST_INIT;
                        time_d = TIME_RESET;
                        stat_d = '0;
                    end
                end
                ST_ERROR: begin
                    host_sync_d = LINE_STOP;
                    stat_d.seq_error = 1'b1;
                    if (cmd.restart) begin
                        // The operator's restart is what clears the sequencing flag.
                        state_d = ST_INIT;
                        time_d = TIME_RESET;
                        stat_d = '0;
                    end
                end
                default: begin
                    state_d = ST_INIT;
                end
            endcase
        end
    end

    // State registers; reset lands in Initialize with everything stopped.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_INIT;
            host_sync_q <= LINE_STOP;
            time_q <= TIME_RESET;
            end_q <= TIME_RESET;
            stat_q <= '0;
        end else begin
            state_q <= state_d;
            host_sync_q <= host_sync_d;
            time_q <= time_d;
            end_q <= end_d;
            stat_q <= stat_d;
        end
    end

    assign host_sync = host_sync_q;
    assign state = state_q;
    assign status = stat_q;
    assign exp_time = time_q;
    assign end_time = end_q;

    // Checks on the sequencing.
    a_init_line_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_INIT) |-> (host_sync_q == LINE_STOP && time_q == TIME_RESET))
        else $error("Sync high or clock nonzero in Initialize.");
    a_ready_raises: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_READY) |-> (host_sync_q == LINE_RUN && !stat_q.clocks_running && !stat_q.logging))
        else $error("Ready state with wrong outputs.");
    a_rise_starts: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_READY && rise && !cmd.manual_nogo_command) |=> (state_q == ST_RUN && stat_q.clocks_running))
        else $error("Partner rise did not start run.");
    a_abort_stops: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd.manual_nogo_command && state_q == ST_RUN) |=>
        (state_q == ST_ABORT && host_sync_q == LINE_STOP && stat_q.discard_logs) ##1 (state_q == ST_IDLE))
        else $error("Abort did not stop the run.");
    a_halt_ack: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_RUN && fall && !cmd.manual_nogo_command) |=>
        (state_q == ST_HALT_ACK && host_sync_q == LINE_STOP && end_q == $past(time_q) && stat_q.flush_logs))
        else $error("Halt acknowledge wrong.");
    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_IDLE) |-> (host_sync_q == LINE_STOP && !stat_q.clocks_running))
        else $error("Idle with sync high or clocks running.");
    a_early_error: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_INIT && sync2_q && !cmd.manual_nogo_command) |=>
        (state_q == ST_ERROR && host_sync_q == LINE_STOP && stat_q.seq_error))
        else $error("Early partner run not flagged.");
    a_clock_frozen: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_HALT_ACK && !cmd.manual_nogo_command) |=> (state_q == ST_IDLE && $stable(time_q)))
        else $error("Clock moved after halt.");
    a_sync_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(sync2_q) |-> (rise ##1 !rise))
        else $error("Synchronised rise not seen exactly once.");

    // Further checks on abort, run timing and the quiet states.
    a_nogo_early: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmd.manual_nogo_command && (state_q == ST_INIT || state_q == ST_READY)) |=>
        (state_q == ST_ABORT && host_sync_q == LINE_STOP))
        else $error("No-go before run did not abort.");
    a_run_counts: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_RUN && !fall && !cmd.manual_nogo_command) |=> (time_q == $past(time_q) + 32'h0000_0001))
        else $error("Experiment clock did not advance in run.");
    a_run_line: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_RUN) |-> (host_sync_q == LINE_RUN && stat_q.clocks_running && stat_q.logging))
        else $error("Run state with wrong outputs.");
    a_flush_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
        stat_q.flush_logs |=> !stat_q.flush_logs)
        else $error("Flush pulse longer than one cycle.");
    a_halt_stopped: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_HALT_ACK) |-> (!stat_q.clocks_running && host_sync_q == LINE_STOP))
        else $error("Clocks running or sync high in halt acknowledge.");
    a_idle_waits: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_IDLE && !cmd.restart) |=> (state_q == ST_IDLE))
        else $error("Idle left without a restart.");
    a_error_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_ERROR) |-> (host_sync_q == LINE_STOP && stat_q.seq_error))
        else $error("Error state with sync high or flag clear.");

endmodule : start_sync_host

// ---- core/sync_pkg.sv ----
package sync_pkg;

    // Sync line levels: high asks to run, low asks to stop.
    localparam logic LINE_RUN = 1'b1;
    localparam logic LINE_STOP = 1'b0;

    // Experiment clock width and its value while initializing.
    localparam int TIME_W = 32;
    localparam logic [TIME_W-1:0] TIME_RESET = 32'h0000_0000;

    // Host sequencing states.
    typedef enum logic [2:0] {
        ST_INIT,
        ST_READY,
        ST_RUN,
        ST_ABORT,
        ST_HALT_ACK,
        ST_IDLE,
        ST_ERROR
    } host_state_t;

    // Operator command strobes from the host's own logic.
    typedef struct packed {
        logic ready;
        logic manual_go_command;
        logic manual_nogo_command;
        logic restart;
    } host_cmd_t;

    // Experiment status flags.
    typedef struct packed {
        logic clocks_running;
        logic logging;
        logic discard_logs;
        logic flush_logs;
        logic seq_error;
    } host_status_t;

endpackage : sync_pkg

// ---- testbench/experiment_start_sync_handshake_bench.sv ----
module experiment_start_sync_handshake_bench import sync_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {host_cmd_t c; host_state_t s; logic y; host_status_t f;} row_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic arm = 1'b0;
    logic early = 1'b0;
    host_cmd_t cmd = '0;
    logic partner_sync;
    logic host_sync;
    host_state_t state;
    host_status_t status;
    logic [TIME_W-1:0] exp_time;
    logic [TIME_W-1:0] end_time;
    logic [TIME_W-1:0] t_mark;
    int err_count = 0;
    int comparisons = 0;
    // Command, next state, host line, status; refused commands must leave Idle alone.
    row_t rows[10] = '{'{4'h8, ST_READY, 1'b1, 5'h00}, '{4'h2, ST_ABORT, 1'b0, 5'h04},
        '{4'h0, ST_IDLE, 1'b0, 5'h04}, '{4'h8, ST_IDLE, 1'b0, 5'h04}, '{4'h2, ST_IDLE, 1'b0, 5'h04},
        '{4'h1, ST_INIT, 1'b0, 5'h00}, '{4'h4, ST_READY, 1'b1, 5'h00}, '{4'h2, ST_ABORT, 1'b0, 5'h04},
        '{4'h0, ST_IDLE, 1'b0, 5'h04}, '{4'h1, ST_INIT, 1'b0, 5'h00}};

    start_sync_host u_start_sync_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd),
        .partner_sync(partner_sync), .host_sync(host_sync), .state(state), .status(status),
        .exp_time(exp_time), .end_time(end_time));
    partner_model #(.LEAD(4), .RUN(20)) u_partner_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .host_sync(host_sync), .arm(arm), .early(early), .partner_sync(partner_sync));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    // One-cycle strobe; returns just after the edge that acted on it.
    task automatic pulse(input host_cmd_t c);
        @(posedge sys_clk) cmd <= c;
        @(posedge sys_clk) cmd <= '0;
        #1;
    endtask : pulse

    // Bounded wait, since partner edges pass a synchronizer first.
    task automatic wait_state(input host_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("state", 32'(state), 32'(s));
    endtask : wait_state

    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    // Free-running 100 MHz clock.
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // The whole sequence needs about 110 cycles, so this margin only trips on a hang.
    initial begin
        repeat (2000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("state", 32'(state), 32'(ST_INIT));
        check("sync", 32'(host_sync), 32'(LINE_STOP));
        check("time", exp_time, TIME_RESET);
        $display("reset test done");
        foreach (rows[i]) begin
            pulse(rows[i].c);
            check("state", 32'(state), 32'(rows[i].s));
            check("sync", 32'(host_sync), 32'(rows[i].y));
            check("status", 32'(status), 32'(rows[i].f));
        end
        $display("command table done");
        @(posedge sys_clk) arm <= 1'b1;
        pulse(4'h8);
        wait_state(ST_RUN);
        check("status", 32'(status), 32'h18);
        t_mark = exp_time;
        repeat (4) @(posedge sys_clk);
        #1;
        check("time", exp_time - t_mark, 32'h4);
        wait_state(ST_HALT_ACK);
        check("sync", 32'(host_sync), 32'(LINE_STOP));
        check("status", 32'(status), 32'h02);
        check("end", end_time, exp_time);
        @(posedge sys_clk);
        #1;
        check("state", 32'(state), 32'(ST_IDLE));
        check("status", 32'(status), 32'h00);
        @(posedge sys_clk) arm <= 1'b0;
        pulse(4'h1);
        check("time", exp_time, TIME_RESET);
        $display("normal run done");
        @(posedge sys_clk) early <= 1'b1;
        wait_state(ST_ERROR);
        check("sync", 32'(host_sync), 32'(LINE_STOP));
        check("status", 32'(status), 32'h01);
        @(posedge sys_clk) early <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pulse(4'h1);
        check("state", 32'(state), 32'(ST_INIT));
        $display("error test done");
        @(posedge sys_clk) arm <= 1'b1;
        pulse(4'h8);
        wait_state(ST_RUN);
        pulse(4'h2);
        check("state", 32'(state), 32'(ST_ABORT));
        check("sync", 32'(host_sync), 32'(LINE_STOP));
        check("status", 32'(status), 32'h04);
        $display("abort test done");
        // A reset must return both sides to Initialize; the partner shares it, so its line drops too.
        @(posedge sys_clk) sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        pulse(4'h8);
        wait_state(ST_RUN);
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("state", 32'(state), 32'(ST_INIT));
        check("sync", 32'(host_sync), 32'(LINE_STOP));
        check("time", exp_time, TIME_RESET);
        check("end", end_time, TIME_RESET);
        check("status", 32'(status), 32'h00);
        @(posedge sys_clk);
        #1;
        check("state", 32'(state), 32'(ST_INIT));
        $display("mid-run reset test done");
        complete_run();
    end
endmodule : experiment_start_sync_handshake_bench

// ---- testbench/partner_model.sv ----
module partner_model #(
    parameter int LEAD = 4, // Sets the delay from Ready to raising the line, LEAD plus two cycles.
    parameter int RUN = 20 // The line stays high for RUN plus one cycles.
) (
    input wire logic sys_clk, // System clock.
    input wire logic sys_rst, // Synchronous active-high reset.
    input wire logic host_sync, // Host line, high asks to run.
    input wire logic arm, // High once partner setup is done.
    input wire logic early, // Raises the line out of turn on purpose.
    output logic partner_sync // Partner line, high asks to run.
);
    timeunit 1ns;
    timeprecision 1ps;
    int phase = 0;
    int cnt = 0;

    // Phases are 0 init, 1 wait, 2 ready, 3 run, 4 halt, 5 idle; the lead stands in for the real one second.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            phase <= 0;
        end else begin
            case (phase)
                0: if (arm) phase <= 1;
                1: if (host_sync) begin phase <= 2; cnt <= LEAD; end
                2: if (cnt == 0) begin phase <= 3; cnt <= RUN; end else cnt <= cnt - 1;
                3: if (cnt == 0) phase <= 4; else cnt <= cnt - 1;
                4: if (!host_sync) phase <= 5;
                default: if (!arm) phase <= 0;
            endcase
        end
    end

    // The line is high only in Run; the early input overrides to provoke a sequencing error.
    assign partner_sync = early || (phase == 3);
endmodule : partner_model
